// file: rtl/spc_pkg.sv
package spc_pkg;

  localparam logic [31:0] SPC_BASE_ADDR   = 32'h0003ff00;
  localparam logic [3:0]  SPC_CPU_SPACE   = 4'h7;
  localparam logic [11:0] SPC_OFF_CONFIG  = 12'h000;
  localparam logic [11:0] SPC_OFF_PROTECT = 12'h004;
  localparam logic [11:0] SPC_OFF_RSTAT   = 12'h008;
  localparam int          SPC_WIN_LSB     = 12;

  localparam logic [19:0] SPC_BASE_RST    = 20'hfffff;
  localparam logic [15:0] SPC_CONFIG_RST  = 16'h0000;
  localparam logic [7:0]  SPC_PROTECT_RST = 8'h00;

  // Protection control field positions
  localparam int SPC_P_BME  = 7;
  localparam int SPC_P_TSEL = 4;
  localparam int SPC_P_DOUBLE_FAULT_RESET_ENABLE = 3;

  // Config field positions
  localparam int SPC_C_IARB  = 0;
  localparam int SPC_C_BUSY  = 6;
  localparam int SPC_C_HALT  = 7;
  localparam int SPC_C_AVEC  = 8;
  localparam int SPC_C_SUPV  = 15;
  localparam int SPC_C_CSF   = 16;
  localparam int SPC_C_SHOW  = 17;
  localparam int SPC_C_FRZ   = 19;

  // Timeout limits in clocks, selected by tsel 0..3
  localparam logic [6:0] SPC_TMO_64 = 7'h40;
  localparam logic [6:0] SPC_TMO_32 = 7'h20;
  localparam logic [6:0] SPC_TMO_16 = 7'h10;
  localparam logic [6:0] SPC_TMO_8  = 7'h08;

  // Reset status bit positions
  localparam int SPC_R_EXT  = 0;
  localparam int SPC_R_POW  = 1;
  localparam int SPC_R_WDG  = 2;
  localparam int SPC_R_DBF  = 3;
  localparam int SPC_R_LOC  = 4;
  localparam int SPC_R_INS  = 5;

  typedef struct packed {
    logic       freeze_stop;
    logic [1:0] show_mode;
    logic       cs_function;
    logic       supv_only;
    logic [6:0] autovector;
    logic [3:0] iarb;
  } spc_cfg_t;

  typedef struct packed {
    logic ext_pin;
    logic power_up;
    logic watchdog;
    logic loss_clock;
    logic reset_instr;
  } spc_rsrc_t;

endpackage

// file: rtl/spc_top.sv
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
// What this block does
// - Config, protection and reset status registers decode inside one relocatable 4-Kbyte window
// - Window upper address comes from base bits 31 to 12
// - Base register answers only at fixed address 0003FF00
// - Config register mixes writable bits with read-only status bits
// - Config selects freeze, show cycles, chip selects, privilege, arbitration, autovector
// - Reset status records the source of the latest reset
// - Monitor times every internal access, external ones when enabled
// - Four selectable timeout limits for internal and external accesses
// - Timeout raises internal bus error only, external line stays undriven
// - Disabling the monitor affects only external cycles
// - Core halt indication triggers a system reset
// - Double-fault reset response can be switched off
// - Timeout limits span 8 to 64 clocks
// - Monitor-enable bit turns on external cycle monitoring
// - Double-fault enable bit gates the monitor reset
// - Double-fault flag set when latest reset came from monitor
module spc_top
  import spc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  function_code_lines,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core bus cycle to monitor
  input  wire logic        cyc_start,
  input  wire logic        cyc_external,
  input  wire logic        cyc_done,
  input  wire logic        core_halt,
  output logic             bus_err_int,
  output logic             bus_error_line_o,
  output logic             bus_error_line_oe,
  // Reset sources and request
  input  wire spc_rsrc_t   rst_src,
  output logic             sys_reset_req,
  // Configuration out
  output spc_cfg_t         cfg
);

  logic [19:0] window_base_bits;
  logic [7:0]  protect;
  logic [5:0]  rstat;
  logic        cyc_active;
  logic [6:0]  cyc_cnt;
  logic        halt_seen;

  // Address decode
  wire         setup      = psel & ~penable & ~pready;
  wire         wr_go      = psel & penable & pready & pwrite;
  wire         hit_base   = (paddr == SPC_BASE_ADDR) &&
                            (function_code_lines == SPC_CPU_SPACE);
  wire         in_window  = (paddr[31:SPC_WIN_LSB] ==
                             window_base_bits) && !hit_base;
  wire [11:0]  off        = paddr[11:0];
  wire         hit_cfg    = in_window && (off == SPC_OFF_CONFIG);
  wire         hit_prot   = in_window && (off == SPC_OFF_PROTECT);
  wire         hit_rst    = in_window && (off == SPC_OFF_RSTAT);
  wire         hit_any    = hit_base | hit_cfg | hit_prot | hit_rst;

  // Configuration word with live status bits inserted
  wire [31:0]  cfg_word   = {12'h000,
                             cfg.freeze_stop, cfg.show_mode,
                             cfg.cs_function, cfg.supv_only,
                             cfg.autovector,
                             halt_seen, cyc_active, 2'h0,
                             cfg.iarb};
  wire [31:0]  rd_mux     = hit_base ? {window_base_bits, 12'h000} :
                            hit_cfg  ? cfg_word :
                            hit_prot ? {24'h000000, protect} :
                            hit_rst  ? {26'h0000000, rstat} :
                                       32'h00000000;

  // Zero wait state APB: ready in every access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit_any;
      prdata  <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // Writable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      window_base_bits <= SPC_BASE_RST;
      protect          <= SPC_PROTECT_RST;
      cfg              <= SPC_CONFIG_RST;
    end else if (wr_go) begin
      if (hit_base)
        window_base_bits <= pwdata[31:SPC_WIN_LSB];
      if (hit_prot)
        protect <= pwdata[7:0];
      if (hit_cfg) begin
        cfg.iarb        <= pwdata[SPC_C_IARB +: 4];
        cfg.autovector  <= pwdata[SPC_C_AVEC +: 7];
        cfg.supv_only   <= pwdata[SPC_C_SUPV];
        cfg.cs_function <= pwdata[SPC_C_CSF];
        cfg.show_mode   <= pwdata[SPC_C_SHOW +: 2];
        cfg.freeze_stop <= pwdata[SPC_C_FRZ];
      end
    end
  end

  // Bus monitor
  wire         external_monitor_enable        = protect[SPC_P_BME];
  wire [1:0]   tsel       = protect[SPC_P_TSEL +: 2];
  wire         double_fault_reset_enable       = protect[SPC_P_DOUBLE_FAULT_RESET_ENABLE];
  wire [6:0]   limit      = (tsel == 2'h0) ? SPC_TMO_64 :
                            (tsel == 2'h1) ? SPC_TMO_32 :
                            (tsel == 2'h2) ? SPC_TMO_16 :
                                             SPC_TMO_8;
  logic        cyc_ext_q;
  wire         monitored  = !cyc_ext_q || external_monitor_enable;
  wire         timeout    = cyc_active && monitored && !cyc_done &&
                            (cyc_cnt == limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_active <= 1'b0;
      cyc_ext_q  <= 1'b0;
      cyc_cnt    <= 7'h00;
    end else if (cyc_start) begin
      cyc_active <= 1'b1;
      cyc_ext_q  <= cyc_external;
      cyc_cnt    <= 7'h01;
    end else if (cyc_active) begin
      if (cyc_done || timeout)
        cyc_active <= 1'b0;
      else if (cyc_cnt != limit)
        cyc_cnt <= cyc_cnt + 7'h01;
    end
  end

  // Error stays internal; the shared line is never driven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_err_int       <= 1'b0;
      bus_error_line_o  <= 1'b0;
      bus_error_line_oe <= 1'b0;
    end else begin
      bus_err_int       <= timeout;
      bus_error_line_o  <= 1'b0;
      bus_error_line_oe <= 1'b0;
    end
  end

  // Double fault monitor; request holds until the system reset lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_reset_req <= 1'b0;
      halt_seen     <= 1'b0;
    end else begin
      if (core_halt && double_fault_reset_enable)
        sys_reset_req <= 1'b1;
      if (core_halt)
        halt_seen <= 1'b1;
    end
  end

  // Reset status must survive the reset it records, so presetn does
  // not touch it; a power-up pulse gives it a defined start value.
  wire [5:0]   next_rstat =
    rst_src.power_up    ? 6'h01 << SPC_R_POW :
    sys_reset_req       ? 6'h01 << SPC_R_DBF :
    rst_src.watchdog    ? 6'h01 << SPC_R_WDG :
    rst_src.loss_clock  ? 6'h01 << SPC_R_LOC :
    rst_src.ext_pin     ? 6'h01 << SPC_R_EXT :
                          6'h01 << SPC_R_INS;
  wire         any_src    = rst_src.power_up | sys_reset_req |
                            rst_src.watchdog | rst_src.loss_clock |
                            rst_src.ext_pin | rst_src.reset_instr;

  always_ff @(posedge pclk) begin
    if (any_src)
      rstat <= next_rstat;
  end

  // Bus monitor checks
  AST_TIMEOUT_ERR: assert property (
    @(posedge pclk) disable iff (!presetn)
    timeout |=> bus_err_int)
    else $error("timeout did not raise internal error");

  AST_NO_EXT_DRIVE: assert property (
    @(posedge pclk) disable iff (!presetn)
    !bus_error_line_oe)
    else $error("external bus error line driven");

  // Internal cycles are timed whatever the enable bit says
  AST_INT_ALWAYS: assert property (
    @(posedge pclk) disable iff (!presetn)
    (cyc_start && !cyc_external && protect[SPC_P_TSEL +: 2] == 2'h3
     && !wr_go) ##1 (!cyc_done && !cyc_start)[*8] |=> bus_err_int)
    else $error("internal cycle not timed at 8 clocks");

  AST_EXT_OFF: assert property (
    @(posedge pclk) disable iff (!presetn)
    (cyc_active && cyc_ext_q && !external_monitor_enable) |-> !timeout)
    else $error("external cycle timed while monitor off");

  AST_NO_EARLY: assert property (
    @(posedge pclk) disable iff (!presetn)
    bus_err_int |-> $past(cyc_cnt) == $past(limit))
    else $error("timeout fired at wrong count");

  AST_LIMIT_RANGE: assert property (
    @(posedge pclk) disable iff (!presetn)
    limit >= SPC_TMO_8 && limit <= SPC_TMO_64)
    else $error("limit outside 8 to 64");

  AST_DONE_STOPS: assert property (
    @(posedge pclk) disable iff (!presetn)
    (cyc_active && cyc_done && !cyc_start) |=> !cyc_active && !bus_err_int)
    else $error("acknowledge did not stop monitor");

  AST_CYC_RESTART: assert property (
    @(posedge pclk) disable iff (!presetn)
    cyc_start |=> cyc_active && cyc_cnt == 7'h01)
    else $error("new cycle did not restart the counter");

  // Double fault checks
  AST_DBF_RESET: assert property (
    @(posedge pclk) disable iff (!presetn)
    (core_halt && double_fault_reset_enable) |=> sys_reset_req)
    else $error("double fault gave no reset");

  AST_DBF_OFF: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!sys_reset_req && !(core_halt && double_fault_reset_enable)) |=> !sys_reset_req)
    else $error("reset without enabled double fault");

  // No disable here: the flag must hold across the reset it records
  AST_DBF_FLAG: assert property (
    @(posedge pclk)
    (sys_reset_req && !rst_src.power_up) |=> rstat[SPC_R_DBF])
    else $error("double fault flag not recorded");

  AST_HALT_SEEN: assert property (
    @(posedge pclk) disable iff (!presetn)
    core_halt |=> halt_seen)
    else $error("halt status bit not set");

  // Register bus checks
  AST_BASE_SPACE: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_go && paddr == SPC_BASE_ADDR && function_code_lines != SPC_CPU_SPACE)
    |=> $stable(window_base_bits))
    else $error("base register written outside cpu space");

  AST_BASE_WRITE: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_go && hit_base) |=>
    {window_base_bits, 12'h000} == ($past(pwdata) & 32'hfffff000))
    else $error("base register did not take written bits");

  AST_RO_STATUS: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit_cfg) |=>
    prdata[SPC_C_BUSY] == $past(cyc_active))
    else $error("status bit not shown in config read");

  AST_APB_READY: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup |=> pready)
    else $error("no ready in access phase");

  // Refused accesses answer with an error and zero data
  AST_SLVERR: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && !hit_any) |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");

  // Main scenarios reached
  COV_TIMEOUT: cover property (@(posedge pclk) disable iff (!presetn)
    bus_err_int);
  COV_ACK: cover property (@(posedge pclk) disable iff (!presetn)
    cyc_active && cyc_done);
  COV_DBF: cover property (@(posedge pclk) disable iff (!presetn)
    sys_reset_req);
  COV_SLVERR: cover property (@(posedge pclk) disable iff (!presetn)
    pslverr);
  COV_EXT_TIMEOUT: cover property (@(posedge pclk) disable iff (!presetn)
    timeout && cyc_ext_q);

endmodule // spc_top

// file: verification/spc_core_model.sv
`timescale 1ns/1ns
module spc_core_model (
  // From bench
  input  wire logic       pclk,
  input  wire logic       go,
  input  wire logic       ext,
  input  wire logic [7:0] dly,
  input  wire logic       halt_req,
  // Core bus cycle
  output logic            cyc_start,
  output logic            cyc_external,
  output logic            cyc_done,
  output logic            core_halt
);
  logic [7:0] cnt;
  initial begin
    cnt = 8'h00;
    cyc_start = 1'b0;
    cyc_external = 1'b0;
    cyc_done = 1'b0;
    core_halt = 1'b0;
  end
  // Zero delay means the cycle never ends
  always @(posedge pclk) begin
    cyc_start <= go;
    cyc_done <= (cnt == 8'h01);
    // Flip on every clock without go so a stale space flag is never trusted
    cyc_external <= go ? ext : ~cyc_external;
    cnt <= go ? dly : ((cnt != 8'h00) ? cnt - 8'h01 : cnt);
    core_halt <= halt_req;
  end
endmodule // spc_core_model

// file: verification/system_protection_config_tb_top.sv
`timescale 1ns/1ns
module system_protection_config_tb_top;
  import spc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        go, ext, halt_req, bus_error_line, bl_o, bl_oe, srr, cs, cx, cd, ch;
  logic [31:0] paddr, pwdata, prdata, rd, w, base;
  logic [3:0]  fcl;
  logic [7:0]  dly;
  spc_rsrc_t   rst_src;
  spc_cfg_t    cfg;
  int          n_fail, tests_run, cyc, n, lim[4];
  int          prot_m, exp_q[$];

  spc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .function_code_lines(fcl), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cyc_start(cs), .cyc_external(cx), .cyc_done(cd),
    .core_halt(ch), .bus_err_int(bus_error_line), .bus_error_line_o(bl_o),
    .bus_error_line_oe(bl_oe), .rst_src(rst_src), .sys_reset_req(srr),
    .cfg(cfg));
  spc_core_model core_u (.pclk(pclk), .go(go), .ext(ext), .dly(dly),
    .halt_req(halt_req), .cyc_start(cs), .cyc_external(cx),
    .cyc_done(cd), .core_halt(ch));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Whole run needs well under 3000 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // Rule model: clocks until the internal error is seen, 80 for none
  function automatic int model_n(input logic x, input int d);
    int l;
    l = 64 >> prot_m[5:4];
    if ((x && !prot_m[7]) || (d != 0 && d <= l))
      return 80;
    return l + 2;
  endfunction

  task automatic apb(input logic wr, input logic [31:0] a, d,
                     input logic [3:0] f);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    fcl <= f;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    if (wr && a == base + 32'h4)
      prot_m = d;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Expected count: limit plus two when the cycle times out, else 80
  task automatic bus(input logic x, input logic [7:0] d, input int expn);
    @(posedge pclk);
    exp_q.push_back(model_n(x, d));
    go <= 1'b1;
    ext <= x;
    dly <= d;
    @(posedge pclk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (bus_error_line !== 1'b1 && n < 80);
    chk("timeout", n, expn);
    chk("model", n, exp_q.pop_front());
    chk("bus_error_line_pin", {bl_o, bl_oe}, 0);
    repeat (d) @(posedge pclk);
  endtask

  task automatic halt;
    @(posedge pclk);
    halt_req <= 1'b1;
    @(posedge pclk);
    halt_req <= 1'b0;
    @(posedge pclk);
    #1;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, go, ext, halt_req} = '0;
    {paddr, pwdata, fcl, dly, rst_src, n_fail, tests_run, cyc} = '0;
    prot_m = 0;
    lim = '{64, 32, 16, 8};
    void'($urandom(32'ha08d));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    base = {SPC_BASE_RST, 12'h000};
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk);
      rst_src <= spc_rsrc_t'(5'h10 >> i);
      @(posedge pclk);
      rst_src <= '0;
      apb(0, base + 8, 0, 0);
      chk("rstat", rd, 1 << (i + int'(i > 2)));
    end
    apb(0, SPC_BASE_ADDR, 0, SPC_CPU_SPACE);
    chk("base_rst", rd, base);
    apb(1, SPC_BASE_ADDR, 32'h12345abc, 4'h1);
    chk("fc_refused", e, 1);
    apb(1, SPC_BASE_ADDR, 32'h12345abc, SPC_CPU_SPACE);
    apb(0, SPC_BASE_ADDR, 0, SPC_CPU_SPACE);
    chk("base", rd, 32'h12345000);
    apb(0, base, 0, 0);
    chk("old_window", e, 1);
    base = 32'h12345000;
    apb(0, base + 12, 0, 0);
    chk("unmapped", e, 1);
    repeat (4) begin
      w = $urandom;
      apb(1, base, w, 0);
      apb(0, base, 0, 0);
      chk("cfg_rd", rd, w & 32'h000fff0f);
      chk("cfg_out", cfg, {w[19:15], w[14:8], w[3:0]});
    end
    for (int t = 0; t < 4; t++) begin
      apb(1, base + 4, t << 4, 0);
      bus(0, 0, lim[t] + 2);
      bus(0, 8'(lim[t]), 80);
      bus(0, 8'(lim[t] + 1), lim[t] + 2);
    end
    bus(1, 0, 80);
    apb(0, base, 0, 0);
    chk("busy", rd[6], 1);
    apb(1, base + 4, 32'hb0, 0);
    bus(1, 0, 10);
    halt();
    chk("no_req", srr, 0);
    apb(0, base, 0, 0);
    chk("halt_seen", rd[7], 1);
    apb(1, base + 4, 32'h08, 0);
    halt();
    chk("req", srr, 1);
    apb(0, base + 8, 0, 0);
    chk("rstat_dbf", rd, 32'h08);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    prot_m = 0;
    #1;
    chk("req_clr", srr, 0);
    apb(0, 32'hfffff008, 0, 0);
    chk("rstat_keep", rd, 32'h08);
    final_report();
  end
endmodule // system_protection_config_tb_top
